// ==== dmc_pkg.sv ====
/*
 * Shared constants for the mode-control register bank of a stereo DAC:
 * register indices, field positions, reset values and counts.
 * Assumes nothing of its surroundings; every design file names it.
 */
package dmc_pkg;

   // ********************************
   // Control word layout
   // ********************************
   localparam int WORD_BITS = 16;
   localparam int BIT_WORD_TOP = 15;
   localparam logic [4:0] WORD_COUNT = 5'h10;
   localparam logic [4:0] COUNT_OVER = 5'h11;

   // ********************************
   // Register indices
   // ********************************
   localparam logic [6:0] IDX_ATTEN_LEFT = 7'h10;
   localparam logic [6:0] IDX_ATTEN_RIGHT = 7'h11;
   localparam logic [6:0] IDX_MUTE_RATE = 7'h12;
   localparam logic [6:0] IDX_OUT_DEEMPH = 7'h13;
   localparam logic [6:0] IDX_FORMAT = 7'h14;
   localparam logic [6:0] IDX_RANGE = 7'h15;
   localparam logic [6:0] IDX_PHASE_ZERO = 7'h16;

   // ********************************
   // Field positions
   // ********************************
   localparam int BIT_SILENCE_L = 0;
   localparam int BIT_SILENCE_R = 1;
   localparam int BIT_OVER = 6;
   localparam int BIT_REINIT = 7;
   localparam int BIT_OFF_L = 0;
   localparam int BIT_OFF_R = 1;
   localparam int BIT_DEEMPH = 4;
   localparam int BIT_RATE_LO = 5;
   localparam int BIT_RATE_HI = 6;
   localparam int BIT_FMT_LO = 0;
   localparam int BIT_FMT_HI = 2;
   localparam int BIT_ROLLOFF = 5;
   localparam int BIT_RANGE = 0;
   localparam int BIT_INVERT = 0;
   localparam int BIT_ZPOL = 1;
   localparam int BIT_ZCOMB = 2;

   // ********************************
   // Reset values and code limits
   // ********************************
   localparam logic [7:0] RST_ATTEN = 8'hFF;
   localparam logic [2:0] RST_FORMAT = 3'h5;
   localparam logic [1:0] RST_RATE = 2'h0;
   localparam logic [7:0] CODE_FULL = 8'hFF;
   localparam logic [7:0] FLOOR_FINE = 8'h80;
   localparam logic [7:0] FLOOR_WIDE = 8'h9A;
   localparam logic [7:0] HALF_DB_SILENT = 8'hFF;

   // ********************************
   // Counts of cycles and samples
   // ********************************
   localparam int REINIT_CYCLES = 1024;
   localparam logic [10:0] REINIT_LOAD = 11'(REINIT_CYCLES);
   localparam int STEP_SAMPLES = 8;
   localparam logic [2:0] STEP_LAST = 3'(STEP_SAMPLES - 1);

   // Serial port receiver states
   typedef enum logic [0:0] {
      PS_IDLE = 1'b0,
      PS_SHIFT = 1'b1
   } dmc_port_state_t;

endpackage : dmc_pkg

// ==== dmc_shift.sv ====
/*
 * Serial control port receiver: shifts the 16-bit word in on rising
 * shift clock edges while select is low, and pulses a write when
 * select returns high after exactly sixteen clocks.
 * Assumes all three inputs are already synchronised to clk.
 */
`timescale 1ns/1ps
`default_nettype none

module dmc_shift (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Synchronised port pins
   input wire logic port_select_n,
   input wire logic port_shift_clock,
   input wire logic port_serial_in,
   // Received word
   output logic wr,
   output logic [15:0] wr_word
);

   dmc_pkg::dmc_port_state_t state;
   logic sck_prev;
   logic sel_prev;
   logic [4:0] count;
   logic [15:0] shreg;

   // Edge memory for clock and select
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         sck_prev <= 1'b0;
         sel_prev <= 1'b1;
      end else begin
         sck_prev <= port_shift_clock;
         sel_prev <= port_select_n;
      end
   end

   // Frame state, bit count and shifter, MSB first
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         state <= dmc_pkg::PS_IDLE;
         count <= 5'h00;
         shreg <= 16'h0000;
         wr <= 1'b0;
      end else begin
         wr <= 1'b0;
         case (state)
            dmc_pkg::PS_IDLE: begin
               if (sel_prev && !port_select_n) begin
                  state <= dmc_pkg::PS_SHIFT;
                  count <= 5'h00;
               end
            end
            dmc_pkg::PS_SHIFT: begin
               if (port_select_n) begin
                  // Latch on select rise, only a whole word
                  state <= dmc_pkg::PS_IDLE;
                  wr <= (count == dmc_pkg::WORD_COUNT);
               end else if (port_shift_clock && !sck_prev) begin
                  shreg <= {shreg[14:0], port_serial_in};
                  // Saturate so long frames are refused
                  if (count != dmc_pkg::COUNT_OVER) begin
                     count <= count + 5'h01;
                  end
               end
            end
            default: state <= dmc_pkg::PS_IDLE;
         endcase
      end
   end

   assign wr_word = shreg;

endmodule : dmc_shift

`default_nettype wire

// ==== dmc_ramp.sv ====
/*
 * One channel's attenuation ramp: moves the applied code one step per
 * tick toward the programmed code, or toward the silent floor while
 * soft silence is on. Assumes tick is a one-cycle pulse every eight
 * sample periods and clr is a synchronous reinitialise.
 */
`timescale 1ns/1ps
`default_nettype none

module dmc_ramp (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   input wire logic clr,
   // Step timing
   input wire logic tick,
   // Settings
   input wire logic [7:0] target,
   input wire logic silence,
   input wire logic [7:0] floor_code,
   // Applied code
   output logic [7:0] level
);

   logic [7:0] goal;

   // Silence ramps to the floor, which is already full mute
   always_comb begin
      if (silence || (target < floor_code)) begin
         goal = floor_code;
      end else begin
         goal = target;
      end
   end

   // One step per tick in either direction
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         level <= dmc_pkg::RST_ATTEN;
      end else if (clr) begin
         level <= dmc_pkg::RST_ATTEN;
      end else if (tick) begin
         if (level < goal) begin
            level <= level + 8'h01;
         end else if (level > goal) begin
            level <= level - 8'h01;
         end
      end
   end

endmodule : dmc_ramp

`default_nettype wire

// ==== dmc_regs.sv ====
/*
 * Mode-control register bank of a stereo audio DAC: serial port
 * capture, seven write-only registers, soft reinitialise, and the two
 * attenuation ramps paced by the sample clock.
 * Assumes the port pins and the sample clock come from outside the
 * CLK domain; each passes two flip-flops before use. CLK is far
 * faster than the shift clock and the sample clock.
 */
`timescale 1ns/1ps
`default_nettype none

module dmc_regs (
   // Clock and reset
   input wire logic CLK,
   input wire logic RST,
   // Serial control port pins
   input wire logic PORT_SELECT_N,
   input wire logic PORT_SHIFT_CLOCK,
   input wire logic PORT_SERIAL_IN,
   // Sample rate clock
   input wire logic SAMPLE_CLOCK,
   // Applied attenuation codes
   output logic [7:0] LEFT_LEVEL,
   output logic [7:0] RIGHT_LEVEL,
   // Attenuation in half dB, FFh when silent
   output logic [7:0] LEFT_ATTEN_HALF_DB,
   output logic [7:0] RIGHT_ATTEN_HALF_DB,
   output logic LEFT_SILENT,
   output logic RIGHT_SILENT,
   // Channel and converter control
   output logic [1:0] CHANNEL_OFF,
   output logic OVERSAMPLE_DOUBLE,
   output logic DEEMPH_ENABLE,
   output logic [1:0] DEEMPH_RATE_SEL,
   output logic [2:0] INPUT_FORMAT_SEL,
   output logic ROLLOFF_SEL,
   output logic ATTEN_RANGE_MODE,
   output logic OUTPUT_INVERT,
   output logic ZERO_POLARITY,
   output logic ZERO_COMBINE,
   // Soft reinitialise in progress
   output logic REINIT_BUSY
);

   // ********************************
   // Decoding helpers
   // ********************************

   // Full mute threshold for the range mode
   function automatic logic [7:0] floor_of(input logic wide);
      floor_of = wide ? dmc_pkg::FLOOR_WIDE : dmc_pkg::FLOOR_FINE;
   endfunction : floor_of

   // Code at or below the threshold is infinite attenuation
   function automatic logic is_silent(input logic [7:0] code,
                                      input logic wide);
      is_silent = (code <= floor_of(wide));
   endfunction : is_silent

   // Half-dB units: fine is one unit per code, wide is two
   function automatic logic [7:0] half_db(input logic [7:0] code,
                                          input logic wide);
      logic [7:0] diff;
      diff = dmc_pkg::CODE_FULL - code;
      if (is_silent(code, wide)) begin
         half_db = dmc_pkg::HALF_DB_SILENT;
      end else if (wide) begin
         half_db = {diff[6:0], 1'b0};
      end else begin
         half_db = diff;
      end
   endfunction : half_db

   // ********************************
   // Pin synchronisers
   // ********************************

   logic [3:0] sync1;
   logic [3:0] sync2;

   // Two flops per pin; only sync2 is read
   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         sync1 <= 4'h1;
         sync2 <= 4'h1;
      end else begin
         sync1 <= {SAMPLE_CLOCK, PORT_SERIAL_IN, PORT_SHIFT_CLOCK,
                   PORT_SELECT_N};
         sync2 <= sync1;
      end
   end

   // ********************************
   // Serial capture
   // ********************************

   logic wr;
   logic [15:0] wr_word;

   dmc_shift u_shift (
      .clk(CLK),
      .rst(RST),
      .port_select_n(sync2[0]),
      .port_shift_clock(sync2[1]),
      .port_serial_in(sync2[2]),
      .wr(wr),
      .wr_word(wr_word)
   );

   logic [6:0] reg_index;
   logic [7:0] wdata;
   logic reinit;
   logic accept;

   assign reg_index = wr_word[14:8];
   assign wdata = wr_word[7:0];
   // Top bit must be zero; writes during reinit are dropped
   assign accept = wr && !wr_word[dmc_pkg::BIT_WORD_TOP] && !reinit;

   // ********************************
   // Soft reinitialise
   // ********************************

   logic [10:0] reinit_count;
   logic next_reinit_start;

   assign next_reinit_start = accept &&
      (reg_index == dmc_pkg::IDX_MUTE_RATE) && wdata[dmc_pkg::BIT_REINIT];
   assign reinit = (reinit_count != 11'h000);

   // Counts down 1024 clocks; registers are held at default
   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         reinit_count <= 11'h000;
      end else if (next_reinit_start) begin
         // The start cycle already clears, so it is one of the 1024
         reinit_count <= dmc_pkg::REINIT_LOAD - 11'h001;
      end else if (reinit) begin
         reinit_count <= reinit_count - 11'h001;
      end
   end

   // ********************************
   // Mode registers
   // ********************************

   logic [7:0] atten_left;
   logic [7:0] atten_right;
   logic [1:0] soft_silence_ch;
   logic over;
   logic [1:0] channel_off;
   logic deemph_enable;
   logic [1:0] deemph_rate_sel;
   logic [2:0] input_format_sel;
   logic rolloff_sel;
   logic atten_range_mode;
   logic output_invert;
   logic zero_polarity;
   logic zero_combine;
   logic clr;

   // Start write also clears, so its other bits are discarded
   assign clr = reinit || next_reinit_start;

   // Attenuation codes, one per channel
   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         atten_left <= dmc_pkg::RST_ATTEN;
         atten_right <= dmc_pkg::RST_ATTEN;
      end else if (clr) begin
         atten_left <= dmc_pkg::RST_ATTEN;
         atten_right <= dmc_pkg::RST_ATTEN;
      end else if (accept) begin
         if (reg_index == dmc_pkg::IDX_ATTEN_LEFT) begin
            atten_left <= wdata;
         end
         if (reg_index == dmc_pkg::IDX_ATTEN_RIGHT) begin
            atten_right <= wdata;
         end
      end
   end

   // Silence and oversample bits; reserved bits ignored
   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         soft_silence_ch <= 2'h0;
         over <= 1'b0;
      end else if (clr) begin
         soft_silence_ch <= 2'h0;
         over <= 1'b0;
      end else if (accept && (reg_index == dmc_pkg::IDX_MUTE_RATE)) begin
         soft_silence_ch <= {wdata[dmc_pkg::BIT_SILENCE_R],
                             wdata[dmc_pkg::BIT_SILENCE_L]};
         over <= wdata[dmc_pkg::BIT_OVER];
      end
   end

   // Channel off and de-emphasis controls
   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         channel_off <= 2'h0;
         deemph_enable <= 1'b0;
         deemph_rate_sel <= dmc_pkg::RST_RATE;
      end else if (clr) begin
         channel_off <= 2'h0;
         deemph_enable <= 1'b0;
         deemph_rate_sel <= dmc_pkg::RST_RATE;
      end else if (accept && (reg_index == dmc_pkg::IDX_OUT_DEEMPH)) begin
         channel_off <= {wdata[dmc_pkg::BIT_OFF_R],
                         wdata[dmc_pkg::BIT_OFF_L]};
         deemph_enable <= wdata[dmc_pkg::BIT_DEEMPH];
         deemph_rate_sel <=
            wdata[dmc_pkg::BIT_RATE_HI:dmc_pkg::BIT_RATE_LO];
      end
   end

   // Format, rolloff, range, phase and zero flag controls
   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         input_format_sel <= dmc_pkg::RST_FORMAT;
         rolloff_sel <= 1'b0;
         atten_range_mode <= 1'b0;
         output_invert <= 1'b0;
         zero_polarity <= 1'b0;
         zero_combine <= 1'b0;
      end else if (clr) begin
         input_format_sel <= dmc_pkg::RST_FORMAT;
         rolloff_sel <= 1'b0;
         atten_range_mode <= 1'b0;
         output_invert <= 1'b0;
         zero_polarity <= 1'b0;
         zero_combine <= 1'b0;
      end else if (accept) begin
         if (reg_index == dmc_pkg::IDX_FORMAT) begin
            input_format_sel <=
               wdata[dmc_pkg::BIT_FMT_HI:dmc_pkg::BIT_FMT_LO];
            rolloff_sel <= wdata[dmc_pkg::BIT_ROLLOFF];
         end
         if (reg_index == dmc_pkg::IDX_RANGE) begin
            atten_range_mode <= wdata[dmc_pkg::BIT_RANGE];
         end
         if (reg_index == dmc_pkg::IDX_PHASE_ZERO) begin
            output_invert <= wdata[dmc_pkg::BIT_INVERT];
            zero_polarity <= wdata[dmc_pkg::BIT_ZPOL];
            zero_combine <= wdata[dmc_pkg::BIT_ZCOMB];
         end
      end
   end

   // ********************************
   // Step pacing from the sample clock
   // ********************************

   logic sample_prev;
   logic [2:0] sample_count;
   logic tick;

   // Sample edges counted here, not a fixed CLK divide
   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         sample_prev <= 1'b0;
         sample_count <= 3'h0;
      end else begin
         sample_prev <= sync2[3];
         if (clr) begin
            sample_count <= 3'h0;
         end else if (sync2[3] && !sample_prev) begin
            sample_count <= sample_count + 3'h1;
         end
      end
   end

   // One pulse per eight sample periods
   assign tick = sync2[3] && !sample_prev &&
                 (sample_count == dmc_pkg::STEP_LAST);

   // ********************************
   // Channel ramps and reported levels
   // ********************************

   logic [7:0] targets [2];
   logic [7:0] levels [2];
   logic [7:0] halfs [2];
   logic [1:0] silents;

   assign targets[0] = atten_left;
   assign targets[1] = atten_right;

   // Independent ramp state per channel
   for (genvar ch = 0; ch < 2; ch++) begin : g_ch
      dmc_ramp u_ramp (
         .clk(CLK),
         .rst(RST),
         .clr(clr),
         .tick(tick),
         .target(targets[ch]),
         .silence(soft_silence_ch[ch]),
         .floor_code(floor_of(atten_range_mode)),
         .level(levels[ch])
      );

      // Registered decode of the applied code
      always_ff @(posedge CLK or posedge RST) begin
         if (RST) begin
            halfs[ch] <= 8'h00;
            silents[ch] <= 1'b0;
         end else begin
            halfs[ch] <= half_db(levels[ch], atten_range_mode);
            silents[ch] <= is_silent(levels[ch], atten_range_mode);
         end
      end
   end

   // ********************************
   // Outputs, all from flip-flops
   // ********************************

   assign LEFT_LEVEL = levels[0];
   assign RIGHT_LEVEL = levels[1];
   assign LEFT_ATTEN_HALF_DB = halfs[0];
   assign RIGHT_ATTEN_HALF_DB = halfs[1];
   assign LEFT_SILENT = silents[0];
   assign RIGHT_SILENT = silents[1];
   assign CHANNEL_OFF = channel_off;
   assign OVERSAMPLE_DOUBLE = over;
   assign DEEMPH_ENABLE = deemph_enable;
   assign DEEMPH_RATE_SEL = deemph_rate_sel;
   assign INPUT_FORMAT_SEL = input_format_sel;
   assign ROLLOFF_SEL = rolloff_sel;
   assign ATTEN_RANGE_MODE = atten_range_mode;
   assign OUTPUT_INVERT = output_invert;
   assign ZERO_POLARITY = zero_polarity;
   assign ZERO_COMBINE = zero_combine;
   // Busy is clr, not the count, held in a register one cycle later
   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         REINIT_BUSY <= 1'b0;
      end else begin
         REINIT_BUSY <= clr;
      end
   end

endmodule : dmc_regs

`default_nettype wire

// ==== dmc_monitor.sv ====
/*
 * Checker for the DAC mode-control bank: ramp steps, mute floors,
 * half-dB readout, reinitialise length and defaults.
 * Assumes it sees only the top ports and is bound from the bench.
 */
`timescale 1ns/1ps
`default_nettype none

module dmc_monitor (
   // Clock and reset
   input wire logic CLK,
   input wire logic RST,
   // Observed ports
   input wire logic PORT_SELECT_N,
   input wire logic [7:0] LEFT_LEVEL,
   input wire logic [7:0] RIGHT_LEVEL,
   input wire logic [7:0] LEFT_ATTEN_HALF_DB,
   input wire logic LEFT_SILENT,
   input wire logic RIGHT_SILENT,
   input wire logic [2:0] INPUT_FORMAT_SEL,
   input wire logic ATTEN_RANGE_MODE,
   input wire logic REINIT_BUSY
);
   // ********************************
   // Helper logic
   // ********************************
   logic m1;
   logic m2;
   logic mstab;
   logic [7:0] fl;
   int busy_cnt;
   default clocking @(posedge CLK); endclocking
   default disable iff (RST);

   // Mode history: threshold checks skip the cycles of a mode switch
   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         m1 <= 1'b0;
         m2 <= 1'b0;
      end else begin
         m1 <= ATTEN_RANGE_MODE;
         m2 <= m1;
      end
   end

   // Length of the present busy run
   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         busy_cnt <= 0;
      end else begin
         busy_cnt <= REINIT_BUSY ? busy_cnt + 1 : 0;
      end
   end

   assign mstab = (ATTEN_RANGE_MODE == m1) && (m1 == m2);
   assign fl = m1 ? dmc_pkg::FLOOR_WIDE : dmc_pkg::FLOOR_FINE;

   // Expected half-dB readout of one applied code
   function automatic logic [7:0] half(input logic [7:0] l);
      if (l <= fl) begin
         return 8'hFF;
      end
      return m1 ? 8'((8'hFF - l) << 1) : 8'hFF - l;
   endfunction : half

   // ********************************
   // Properties
   // ********************************
   property p_lstep;
      $changed(LEFT_LEVEL) |-> (LEFT_LEVEL - $past(LEFT_LEVEL) == 8'h01 ||
         $past(LEFT_LEVEL) - LEFT_LEVEL == 8'h01) or ##[1:2] REINIT_BUSY;
   endproperty
   a_lstep: assert property (p_lstep) else $error("left jump");
   property p_rstep;
      $changed(RIGHT_LEVEL) |-> (RIGHT_LEVEL - $past(RIGHT_LEVEL) == 8'h01 ||
         $past(RIGHT_LEVEL) - RIGHT_LEVEL == 8'h01) or ##[1:2] REINIT_BUSY;
   endproperty
   a_rstep: assert property (p_rstep) else $error("right jump");
   property p_floor;
      LEFT_LEVEL >= dmc_pkg::FLOOR_FINE && RIGHT_LEVEL >= dmc_pkg::FLOOR_FINE;
   endproperty
   a_floor: assert property (p_floor) else $error("below floor");
   property p_half;
      mstab |-> LEFT_ATTEN_HALF_DB == half($past(LEFT_LEVEL));
   endproperty
   a_half: assert property (p_half) else $error("half dB");
   property p_silent;
      mstab |-> LEFT_SILENT == ($past(LEFT_LEVEL) <= fl) &&
         RIGHT_SILENT == ($past(RIGHT_LEVEL) <= fl);
   endproperty
   a_silent: assert property (p_silent) else $error("silent");
   property p_busy_len;
      $fell(REINIT_BUSY) |-> busy_cnt == dmc_pkg::REINIT_CYCLES;
   endproperty
   a_busy_len: assert property (p_busy_len) else $error("busy");
   property p_busy_def;
      REINIT_BUSY |-> LEFT_LEVEL == 8'hFF && RIGHT_LEVEL == 8'hFF &&
         INPUT_FORMAT_SEL == dmc_pkg::RST_FORMAT && !ATTEN_RANGE_MODE;
   endproperty
   a_busy_def: assert property (p_busy_def) else $error("dflt");
   property p_quiet;
      $changed(INPUT_FORMAT_SEL) || $changed(ATTEN_RANGE_MODE) |->
         $past(PORT_SELECT_N, 3);
   endproperty
   a_quiet: assert property (p_quiet) else $error("early");

   // Main scenarios reached
   c_reinit: cover property ($rose(REINIT_BUSY));
   c_lsil: cover property ($rose(LEFT_SILENT));
   c_rmove: cover property ($changed(RIGHT_LEVEL));

endmodule : dmc_monitor
`default_nettype wire

// ==== dmc_host.sv ====
/*
 * Host model of the serial control port: one word per frame, MSB
 * first, select low around the shift clocks, 48 ns bit period.
 * Assumes calls start on a falling edge of the bench clock.
 */
`timescale 1ns/1ps
`default_nettype none

module dmc_host (
   // Serial control port pins
   output logic port_select_n,
   output logic port_shift_clock,
   output logic port_serial_in
);
   // Idle: select high, shift clock still
   initial begin
      port_select_n = 1'b1;
      port_shift_clock = 1'b0;
      port_serial_in = 1'b0;
   end

   // Send n bits of w; n other than 16 makes a malformed frame
   task automatic send(input logic [16:0] w, input int n);
      int i;
      port_select_n = 1'b0;
      for (i = n - 1; i >= 0; i--) begin
         port_serial_in = w[i];
         #24 port_shift_clock = 1'b1;
         #24 port_shift_clock = 1'b0;
      end
      #24 port_select_n = 1'b1;
      port_serial_in = ~port_serial_in; // Released line shows no stale bit
      #48;
   endtask : send

endmodule : dmc_host
`default_nettype wire

// ==== dmc_regs_tb.sv ====
/*
 * Self-checking bench for the DAC mode-control bank: field table,
 * codes, refused frames, ramps, silence, reset and reinitialise.
 * Assumes the host model drives the port and the bench the fs clock.
 */
`timescale 1ns/1ps
`default_nettype none

module dmc_regs_tb;
   // ********************************
   // Signals and tables
   // ********************************
   logic CLK = 1'b0;
   logic RST = 1'b1;
   logic SAMPLE_CLOCK = 1'b0;
   logic PORT_SELECT_N, PORT_SHIFT_CLOCK, PORT_SERIAL_IN;
   logic [7:0] LEFT_LEVEL, RIGHT_LEVEL;
   logic [7:0] LEFT_ATTEN_HALF_DB, RIGHT_ATTEN_HALF_DB;
   logic LEFT_SILENT, RIGHT_SILENT, OVERSAMPLE_DOUBLE, DEEMPH_ENABLE;
   logic ROLLOFF_SEL, ATTEN_RANGE_MODE, OUTPUT_INVERT, ZERO_POLARITY;
   logic ZERO_COMBINE, REINIT_BUSY;
   logic [1:0] CHANNEL_OFF, DEEMPH_RATE_SEL;
   logic [2:0] INPUT_FORMAT_SEL;
   int err_total = 0;
   int tests_run = 0;
   int busy_cnt = 0;
   int i;
   int c;
   // Words sent, then the field vector each should leave
   // Row five sets doubling, as a host at a low rate would
   logic [15:0] tw [9] = '{16'h1371, 16'h1424, 16'h1501, 16'h1607,
      16'h1240, 16'h1700, 16'h9313, 16'h13AE, 16'h1400};
   logic [13:0] te [9] = '{14'h17A0, 14'h1790, 14'h1798, 14'h179F,
      14'h1F9F, 14'h1F9F, 14'h1F9F, 14'h299F, 14'h290F};

   // Clocks: 4 ns system, 24 ns sample rate, both edges on CLK falls
   always #2 CLK = ~CLK;
   always #12 SAMPLE_CLOCK = ~SAMPLE_CLOCK;
   // Busy length in system clocks
   always @(posedge CLK) if (REINIT_BUSY === 1'b1) busy_cnt <= busy_cnt + 1;

   dmc_host host (.port_select_n(PORT_SELECT_N),
      .port_shift_clock(PORT_SHIFT_CLOCK), .port_serial_in(PORT_SERIAL_IN));
   dmc_regs uut (.CLK(CLK), .RST(RST), .PORT_SELECT_N(PORT_SELECT_N),
      .PORT_SHIFT_CLOCK(PORT_SHIFT_CLOCK), .PORT_SERIAL_IN(PORT_SERIAL_IN),
      .SAMPLE_CLOCK(SAMPLE_CLOCK), .LEFT_LEVEL(LEFT_LEVEL),
      .RIGHT_LEVEL(RIGHT_LEVEL), .LEFT_ATTEN_HALF_DB(LEFT_ATTEN_HALF_DB),
      .RIGHT_ATTEN_HALF_DB(RIGHT_ATTEN_HALF_DB), .LEFT_SILENT(LEFT_SILENT),
      .RIGHT_SILENT(RIGHT_SILENT), .CHANNEL_OFF(CHANNEL_OFF),
      .OVERSAMPLE_DOUBLE(OVERSAMPLE_DOUBLE), .DEEMPH_ENABLE(DEEMPH_ENABLE),
      .DEEMPH_RATE_SEL(DEEMPH_RATE_SEL), .INPUT_FORMAT_SEL(INPUT_FORMAT_SEL),
      .ROLLOFF_SEL(ROLLOFF_SEL), .ATTEN_RANGE_MODE(ATTEN_RANGE_MODE),
      .OUTPUT_INVERT(OUTPUT_INVERT), .ZERO_POLARITY(ZERO_POLARITY),
      .ZERO_COMBINE(ZERO_COMBINE), .REINIT_BUSY(REINIT_BUSY));

   // ********************************
   // Tasks
   // ********************************
   function automatic logic [13:0] obs();
      return {CHANNEL_OFF, OVERSAMPLE_DOUBLE, DEEMPH_ENABLE, DEEMPH_RATE_SEL,
         INPUT_FORMAT_SEL, ROLLOFF_SEL, ATTEN_RANGE_MODE, OUTPUT_INVERT,
         ZERO_POLARITY, ZERO_COMBINE};
   endfunction : obs

   task automatic check(input string nm, input logic [15:0] s, e);
      tests_run++;
      if (s !== e) begin
         err_total++;
         $display("BAD %s expected %h seen %h", nm, e, s);
      end
   endtask : check

   task automatic complete_run();
      $display("checks %0d errors %0d", tests_run, err_total);
      if (err_total == 0 && tests_run > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask : complete_run

   task automatic wr(input logic [15:0] w);
      host.send({1'b0, w}, 16);
      @(negedge CLK);
   endtask : wr

   // Bounded wait for an applied code, then let readouts settle
   task automatic wait_lvl(input logic rt, input logic [7:0] v);
      int n;
      n = 0;
      while ((rt ? RIGHT_LEVEL : LEFT_LEVEL) !== v) begin
         @(negedge CLK);
         n++;
         if (n > 9000) begin
            err_total++;
            complete_run();
         end
      end
      repeat (3) @(negedge CLK);
   endtask : wait_lvl

   // ********************************
   // Main sequence
   // ********************************
   initial begin
      repeat (20) @(negedge CLK);
      RST = 1'b0;
      @(negedge CLK);
      for (i = 0; i < 9; i++) begin
         wr(tw[i]);
         check("fields", 16'(obs()), 16'(te[i]));
      end
      // Reset in mid-run brings every default back
      RST = 1'b1;
      repeat (3) @(negedge CLK);
      RST = 1'b0;
      @(negedge CLK);
      check("rst", 16'(obs()), 16'h00A0);
      check("lvl", {LEFT_LEVEL, RIGHT_LEVEL}, 16'hFFFF);
      check("hdb", {LEFT_ATTEN_HALF_DB, RIGHT_ATTEN_HALF_DB}, 16'h0);
      check("sil", 16'({LEFT_SILENT, RIGHT_SILENT, REINIT_BUSY}), 16'h0);
      for (i = 0; i < 8; i++) begin
         wr(16'h1400 | 16'(i));
         check("fmt", 16'(INPUT_FORMAT_SEL), 16'(i));
      end
      for (i = 0; i < 4; i++) begin
         wr(16'h1300 | 16'(i << 5));
         check("dmf", 16'(DEEMPH_RATE_SEL), 16'(i));
      end
      // Frames of 15 and 17 clocks are dropped
      for (c = 15; c <= 17; c += 2) host.send(17'h01607, c);
      @(negedge CLK);
      check("len", 16'(obs()), 16'h03E0);
      // Fine mode: one step per eight sample periods
      wr(16'h1500);
      wr(16'h10FD);
      wait_lvl(1'b0, 8'hFE);
      c = 0;
      while (LEFT_LEVEL !== 8'hFD && c < 200) begin
         @(negedge CLK);
         c++;
      end
      check("step", 16'(c >= 44 && c <= 46), 16'h1);
      repeat (3) @(negedge CLK);
      check("fine", 16'(LEFT_ATTEN_HALF_DB), 16'h2);
      check("ind", 16'(RIGHT_LEVEL), 16'hFF);
      wr(16'h1501);
      repeat (3) @(negedge CLK);
      check("wide", 16'(LEFT_ATTEN_HALF_DB), 16'h4);
      // Right ramps while left falls to silence
      wr(16'h11F0);
      wr(16'h1201);
      wait_lvl(1'b1, 8'hF0);
      check("rhdb", 16'(RIGHT_ATTEN_HALF_DB), 16'h1E);
      wait_lvl(1'b0, 8'h9A);
      check("mute", {LEFT_ATTEN_HALF_DB, 8'(LEFT_SILENT)}, 16'hFF01);
      wr(16'h1200);
      wait_lvl(1'b0, 8'hFD);
      check("back", 16'(LEFT_SILENT), 16'h0);
      wr(16'h1500);
      wr(16'h1000);
      wait_lvl(1'b0, 8'h80);
      check("fmute", 16'(LEFT_SILENT), 16'h1);
      // Reinitialise; a write during it is dropped
      busy_cnt = 0;
      wr(16'h1280);
      wr(16'h1401);
      c = 0;
      while (REINIT_BUSY !== 1'b0) begin
         @(negedge CLK);
         c++;
         if (c > 3000) begin
            err_total++;
            complete_run();
         end
      end
      check("busy", 16'(busy_cnt), 16'(dmc_pkg::REINIT_CYCLES));
      check("dflt", 16'(obs()), 16'h00A0);
      check("dlvl", {LEFT_LEVEL, RIGHT_LEVEL}, 16'hFFFF);
      complete_run();
   end

endmodule : dmc_regs_tb

bind dmc_regs dmc_monitor mon (.CLK(CLK), .RST(RST),
   .PORT_SELECT_N(PORT_SELECT_N), .LEFT_LEVEL(LEFT_LEVEL),
   .RIGHT_LEVEL(RIGHT_LEVEL), .LEFT_ATTEN_HALF_DB(LEFT_ATTEN_HALF_DB),
   .LEFT_SILENT(LEFT_SILENT), .RIGHT_SILENT(RIGHT_SILENT),
   .INPUT_FORMAT_SEL(INPUT_FORMAT_SEL), .ATTEN_RANGE_MODE(ATTEN_RANGE_MODE),
   .REINIT_BUSY(REINIT_BUSY));
`default_nettype wire
